// >>> src/bank_decode_defs.svh
`ifndef BANK_DECODE_DEFS_SVH
`define BANK_DECODE_DEFS_SVH
`define ADDR_W 12
`define BANK_W 5
`define OFS_W 7
`define DATA_W 8
`define CORE_LAST 7'h0B
`define PERIPH_FIRST 7'h0C
`define PERIPH_LAST 7'h1F
`define GENRAM_FIRST 7'h20
`define GENRAM_LAST 7'h6F
`define COMMON_FIRST 7'h70
`define COMMON_LAST 7'h7F
`define GENRAM_BYTES 80
`define COMMON_BYTES 16
`define CORE_BANK_SEL_OFS 7'h08
`define LINEAR_BASE 16'h2000
`define LINEAR_LAST 16'h29AF
`define BANK_SEL_RST 5'h00
`define GENRAM_BANKS 32
`endif

// >>> src/bank_decode_pkg.sv
package bank_decode_pkg;
    typedef enum logic [2:0] {
        REG_CORE,
        REG_PERIPH,
        REG_GENRAM,
        REG_COMMON,
        REG_NONE
    } region_type;
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } req_type;
    typedef struct packed {
        region_type region;
        logic [11:0] index;
    } target_type;
endpackage : bank_decode_pkg

// >>> src/region_classifier.sv
`timescale 1ns/1ps
`include "bank_decode_defs.svh"
module region_classifier (
    input wire logic [6:0] i_ofs,
    input wire logic [4:0] i_bank,
    output bank_decode_pkg::target_type o_target
);
    always_comb begin
        o_target.region = bank_decode_pkg::REG_NONE;
        o_target.index = 12'h000;
        if (i_ofs <= `CORE_LAST) begin
            o_target.region = bank_decode_pkg::REG_CORE;
            o_target.index = {5'h00, i_ofs};
        end else if (i_ofs <= `PERIPH_LAST) begin
            o_target.region = bank_decode_pkg::REG_PERIPH;
            o_target.index = {i_bank, i_ofs};
        end else if (i_ofs <= `GENRAM_LAST) begin
            o_target.region = bank_decode_pkg::REG_GENRAM;
            // Widen before the product so bank 31 times 80 cannot wrap
            o_target.index = 12'(i_bank) * 12'(`GENRAM_BYTES) + {5'h00, i_ofs - `GENRAM_FIRST};
        end else begin
            o_target.region = bank_decode_pkg::REG_COMMON;
            o_target.index = {8'h00, i_ofs[3:0]};
        end
    end
endmodule : region_classifier

// >>> src/banked_data_memory_decoder.sv
`timescale 1ns/1ps
`include "bank_decode_defs.svh"
// Functional notes
// - Offsets 0Ch..1Fh of every bank decode as the peripheral control region.
// - General RAM is 80 bytes per bank, ending at bank offset 6Fh.
// - General RAM of banks 0..30 also reachable through the linear window via file select pointers; bank 31 is not.
// - Offsets 70h..7Fh in any bank reach one shared 16-byte RAM.
// - Addresses are 12 bits: bank in top five, offset in low seven.
// - First twelve offsets of every bank reach the same core registers.
// - Unimplemented locations read as zero.
// - Direct accesses use the bank select register value as the bank.
module banked_data_memory_decoder (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire logic [6:0] I_DIR_OFS,
    input wire logic I_DIR_RD,
    input wire logic I_DIR_WR,
    input wire logic [15:0] I_PTR_ADDR,
    input wire logic I_PTR_RD,
    input wire logic I_PTR_WR,
    input wire logic [7:0] I_WDATA,
    input wire logic [7:0] I_CORE_RDATA,
    input wire logic [7:0] I_PERIPH_RDATA,
    input wire logic [15:0] I_PERIPH_PRESENT,
    output logic [7:0] O_RDATA,
    output logic [4:0] O_BANK,
    output logic O_CORE_WR,
    output logic O_PERIPH_WR,
    output logic [11:0] O_ADDR,
    output logic [7:0] O_WDATA
);
    ////////////////////////////////////////////////////////////////////////////
    // Bank select register lives here so direct decode sees it the same cycle
    logic [4:0] bank_sel_r;
    logic [4:0] bank_sel_nxt;
    bank_decode_pkg::req_type req;
    bank_decode_pkg::target_type tgt;
    logic lin_hit;
    logic [11:0] lin_idx;
    logic [7:0] genram [0:`GENRAM_BANKS*`GENRAM_BYTES-1];
    logic [7:0] common [0:`COMMON_BYTES-1];
    logic [7:0] rdata_nxt;
    logic [7:0] rdata_r;
    // Write data is registered so it leaves on the same edge as read data
    logic [7:0] wdata_nxt;
    logic [7:0] wdata_r;
    logic bank_wr_hit;
    logic present;

    // A linear window access takes priority over a direct one
    always_comb begin
        lin_hit = (I_PTR_RD || I_PTR_WR) && I_PTR_ADDR >= `LINEAR_BASE && I_PTR_ADDR <= `LINEAR_LAST;
        lin_idx = 12'(I_PTR_ADDR - `LINEAR_BASE);
        req.addr = {bank_sel_r, I_DIR_OFS};
        req.wdata = I_WDATA;
        req.wr = I_DIR_WR;
        req.rd = I_DIR_RD;
    end

    region_classifier u_class (
        .i_ofs(req.addr[6:0]),
        .i_bank(req.addr[11:7]),
        .o_target(tgt)
    );

    function automatic logic periph_ok(input logic [15:0] pres, input logic [4:0] b);
        periph_ok = pres[b[3:0]] && !b[4];
    endfunction : periph_ok

    always_comb begin
        present = periph_ok(I_PERIPH_PRESENT, bank_sel_r);
        O_BANK = bank_sel_r;
        O_ADDR = req.addr;
        O_CORE_WR = !lin_hit && req.wr && tgt.region == bank_decode_pkg::REG_CORE;
        O_PERIPH_WR = !lin_hit && req.wr && tgt.region == bank_decode_pkg::REG_PERIPH && present;
        wdata_nxt = req.wdata;
        // Only a core write at the bank select offset may move the bank
        bank_wr_hit = O_CORE_WR && req.addr[6:0] == `CORE_BANK_SEL_OFS;
        bank_sel_nxt = bank_sel_r;
        if (bank_wr_hit) begin
            bank_sel_nxt = req.wdata[4:0];
        end
        rdata_nxt = 8'h00;
        if (lin_hit) begin
            rdata_nxt = genram[lin_idx];
        end else if (req.rd) begin
            case (tgt.region)
                bank_decode_pkg::REG_CORE: rdata_nxt = (req.addr[6:0] == `CORE_BANK_SEL_OFS) ?
                    {3'h0, bank_sel_r} : I_CORE_RDATA;
                bank_decode_pkg::REG_PERIPH: rdata_nxt = present ? I_PERIPH_RDATA : 8'h00;
                bank_decode_pkg::REG_GENRAM: rdata_nxt = genram[tgt.index];
                bank_decode_pkg::REG_COMMON: rdata_nxt = common[tgt.index[3:0]];
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            bank_sel_r <= `BANK_SEL_RST;
            rdata_r <= 8'h00;
            wdata_r <= 8'h00;
        end else begin
            bank_sel_r <= bank_sel_nxt;
            rdata_r <= rdata_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage has no reset: RAM contents are undefined at power-up
    // A pointer write wins a clash with a direct write, as on the read path
    always_ff @(posedge I_CLK) begin
        if (lin_hit && I_PTR_WR) begin
            genram[lin_idx] <= I_WDATA;
        end else if (!lin_hit && req.wr && tgt.region == bank_decode_pkg::REG_GENRAM) begin
            genram[tgt.index] <= req.wdata;
        end
        if (!lin_hit && req.wr && tgt.region == bank_decode_pkg::REG_COMMON) begin
            common[tgt.index[3:0]] <= req.wdata;
        end
    end

    assign O_RDATA = rdata_r;
    assign O_WDATA = wdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Region decode: every bank must split its offsets the same way
    a_core_shared: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_DIR_OFS <= `CORE_LAST) |-> tgt.region == bank_decode_pkg::REG_CORE && tgt.index[11:7] == 5'h00)
        else $error("core offset not shared");

    a_periph_span: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_DIR_OFS >= `PERIPH_FIRST && I_DIR_OFS <= `PERIPH_LAST) |-> tgt.region == bank_decode_pkg::REG_PERIPH)
        else $error("peripheral span wrong");

    a_genram_span: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_DIR_OFS >= `GENRAM_FIRST && I_DIR_OFS <= `GENRAM_LAST) |-> tgt.region == bank_decode_pkg::REG_GENRAM
        && tgt.index < 12'(`GENRAM_BANKS * `GENRAM_BYTES))
        else $error("general ram span wrong");

    a_common_span: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_DIR_OFS >= `COMMON_FIRST) |-> tgt.region == bank_decode_pkg::REG_COMMON
        && tgt.index == {8'h00, I_DIR_OFS[3:0]})
        else $error("common ram not shared");

    ////////////////////////////////////////////////////////////////////////////
    // Bank select and address forming
    a_bank_write: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_DIR_WR && !lin_hit && I_DIR_OFS == `CORE_BANK_SEL_OFS) |=> O_BANK == $past(I_WDATA[4:0]))
        else $error("bank select not updated");

    // A bank that drifts on its own would send direct accesses to the wrong place
    a_bank_hold: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        !bank_wr_hit |=> O_BANK == $past(O_BANK))
        else $error("bank select moved without a write");

    a_addr_form: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        O_ADDR == {O_BANK, I_DIR_OFS})
        else $error("address not bank plus offset");

    a_bank_read: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_DIR_RD && !lin_hit && I_DIR_OFS == `CORE_BANK_SEL_OFS) |=> O_RDATA == {3'h0, $past(O_BANK)})
        else $error("bank select read back wrong");

    ////////////////////////////////////////////////////////////////////////////
    // Write steering: a write lands in exactly one place or nowhere
    a_core_wr_span: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        O_CORE_WR |-> I_DIR_WR && I_DIR_OFS <= `CORE_LAST)
        else $error("core write outside core offsets");

    a_periph_wr_span: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        O_PERIPH_WR |-> I_DIR_WR && I_DIR_OFS >= `PERIPH_FIRST && I_DIR_OFS <= `PERIPH_LAST)
        else $error("peripheral write outside its offsets");

    a_absent_nowr: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (tgt.region == bank_decode_pkg::REG_PERIPH && !present) |-> !O_PERIPH_WR)
        else $error("write to absent register");

    // Upper sixteen banks carry no peripherals at all
    a_high_bank_nowr: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_DIR_WR && O_BANK[4] && tgt.region == bank_decode_pkg::REG_PERIPH) |-> !O_PERIPH_WR)
        else $error("write to peripheral in upper bank");

    a_ptr_priority: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        lin_hit |-> !O_CORE_WR && !O_PERIPH_WR)
        else $error("direct write beside window access");

    ////////////////////////////////////////////////////////////////////////////
    // Read data: zero unless something implemented was read or the linear window was written
    a_absent_zero: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_DIR_RD && !lin_hit && tgt.region == bank_decode_pkg::REG_PERIPH && !present) |=> O_RDATA == 8'h00)
        else $error("unimplemented read not zero");

    a_idle_zero: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (!I_DIR_RD && !lin_hit) |=> O_RDATA == 8'h00)
        else $error("read data without a read");

    a_periph_read: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (I_DIR_RD && !lin_hit && tgt.region == bank_decode_pkg::REG_PERIPH && present)
        |=> O_RDATA == $past(I_PERIPH_RDATA))
        else $error("peripheral read data lost");

    ////////////////////////////////////////////////////////////////////////////
    // Linear window: must stay inside the general RAM it aliases
    a_window_range: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        lin_hit |-> lin_idx < 12'(`GENRAM_BANKS * `GENRAM_BYTES))
        else $error("window index beyond general ram");

    a_linear_rt: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
        (lin_hit && I_PTR_WR) ##1 (lin_hit && I_PTR_RD && lin_idx == $past(lin_idx)) |=>
        O_RDATA == $past(I_WDATA, 2))
        else $error("linear window round trip");

    ////////////////////////////////////////////////////////////////////////////
    // Main scenarios the bench is expected to reach
    c_bank_change: cover property (@(posedge I_CLK) O_BANK != $past(O_BANK));
    c_common_rd: cover property (@(posedge I_CLK) I_DIR_RD && tgt.region == bank_decode_pkg::REG_COMMON);
    c_linear_wr: cover property (@(posedge I_CLK) lin_hit && I_PTR_WR);
    c_absent_wr: cover property (@(posedge I_CLK) I_DIR_WR && tgt.region == bank_decode_pkg::REG_PERIPH && !present);
    c_linear_rt: cover property (@(posedge I_CLK) (lin_hit && I_PTR_WR) ##1 (lin_hit && I_PTR_RD));
endmodule : banked_data_memory_decoder

// >>> test/core_side_model.sv
`timescale 1ns/1ps
module core_side_model (
    input wire logic [11:0] i_addr,
    output logic [7:0] o_core_rdata,
    output logic [7:0] o_periph_rdata,
    output logic [15:0] o_present
);
    // Peripheral read data follows bank and offset, core read data only the offset, so a wrong address shows up
    assign o_core_rdata = {1'h1, i_addr[6:0]};
    assign o_periph_rdata = {1'h0, i_addr[6:0]} ^ {3'h0, i_addr[11:7]};
    assign o_present = 16'h00FF;
endmodule : core_side_model

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
    logic clk = 1'h0, rst = 1'h1, dir_rd = 1'h0, dir_wr = 1'h0, ptr_rd = 1'h0, ptr_wr = 1'h0;
    logic [6:0] dir_ofs = 7'h00;
    logic [15:0] ptr_addr = 16'h0000, present;
    logic [7:0] wdata = 8'h00, core_rd, per_rd, rdata, wdata_o, rd_seen, wd_seen;
    logic [4:0] bank;
    logic core_wr, per_wr, cwr, pwr;
    logic [11:0] addr, addr_seen;
    int mismatches = 0, samples_checked = 0;
    core_side_model model (.i_addr(addr), .o_core_rdata(core_rd), .o_periph_rdata(per_rd), .o_present(present));
    banked_data_memory_decoder dut (.I_CLK(clk), .I_SYS_RST(rst), .I_DIR_OFS(dir_ofs), .I_DIR_RD(dir_rd),
        .I_DIR_WR(dir_wr), .I_PTR_ADDR(ptr_addr), .I_PTR_RD(ptr_rd), .I_PTR_WR(ptr_wr), .I_WDATA(wdata),
        .I_CORE_RDATA(core_rd), .I_PERIPH_RDATA(per_rd), .I_PERIPH_PRESENT(present), .O_RDATA(rdata),
        .O_BANK(bank), .O_CORE_WR(core_wr), .O_PERIPH_WR(per_wr), .O_ADDR(addr), .O_WDATA(wdata_o));
    initial begin
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        samples_checked++;
        if (e !== g) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // One access held for one cycle; pointer accesses carry p=1
    task automatic acc(input logic p, input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        dir_ofs = a[6:0];
        ptr_addr = a;
        wdata = d;
        {dir_rd, dir_wr, ptr_rd, ptr_wr} = {!p && !w, !p && w, p && !w, p && w};
        #1;
        {cwr, pwr, addr_seen} = {core_wr, per_wr, addr};
        @(negedge clk);
        rd_seen = rdata;
        wd_seen = wdata_o;
        {dir_rd, dir_wr, ptr_rd, ptr_wr} = 4'h0;
    endtask : acc
    task automatic set_bank(input logic [4:0] b);
        acc(1'h0, 1'h1, 16'h0008, {3'h0, b});
        chk("bank", {7'h00, b}, {7'h00, bank});
    endtask : set_bank
    ////////////////////////////////////////////////////////////////////////
    task automatic bank_test;
        chk("bank reset", 12'h000, {7'h00, bank});
        set_bank(5'h03);
        chk("core wr", 12'h001, {11'h0, cwr});
        acc(1'h0, 1'h0, 16'h0008, 8'h00);
        chk("bank read", 12'h003, {4'h0, rd_seen});
        acc(1'h0, 1'h0, 16'h000B, 8'h00);
        chk("addr", 12'h18B, addr_seen);
        chk("core read", 12'h08B, {4'h0, rd_seen});
    endtask : bank_test
    task automatic common_test;
        acc(1'h0, 1'h1, 16'h0075, 8'hA5);
        set_bank(5'h1F);
        acc(1'h0, 1'h0, 16'h0075, 8'h00);
        chk("common", 12'h0A5, {4'h0, rd_seen});
    endtask : common_test
    task automatic genram_test;
        set_bank(5'h03);
        acc(1'h0, 1'h1, 16'h0020, 8'h5A);
        acc(1'h0, 1'h1, 16'h006F, 8'h77);
        acc(1'h1, 1'h0, 16'h20F0, 8'h00);
        chk("linear first", 12'h05A, {4'h0, rd_seen});
        acc(1'h1, 1'h0, 16'h213F, 8'h00);
        chk("linear last", 12'h077, {4'h0, rd_seen});
        acc(1'h1, 1'h1, 16'h29AF, 8'h66);
        acc(1'h1, 1'h0, 16'h29AF, 8'h00);
        chk("window end", 12'h066, {4'h0, rd_seen});
        acc(1'h1, 1'h0, 16'h29B0, 8'h00);
        chk("past window", 12'h000, {4'h0, rd_seen});
    endtask : genram_test
    task automatic periph_test;
        set_bank(5'h00);
        acc(1'h0, 1'h1, 16'h000C, 8'h11);
        chk("periph wr", 12'h001, {11'h0, pwr});
        chk("wdata out", 12'h011, {4'h0, wd_seen});
        acc(1'h0, 1'h0, 16'h001F, 8'h00);
        chk("periph read", 12'h01F, {4'h0, rd_seen});
        acc(1'h0, 1'h1, 16'h000B, 8'h22);
        chk("core not periph", 12'h001, {10'h0, pwr, cwr});
        set_bank(5'h10);
        acc(1'h0, 1'h1, 16'h000C, 8'h33);
        chk("absent wr", 12'h000, {11'h0, pwr});
        acc(1'h0, 1'h0, 16'h000C, 8'h00);
        chk("absent read", 12'h000, {4'h0, rd_seen});
        set_bank(5'h08);
        acc(1'h0, 1'h1, 16'h000C, 8'h44);
        chk("absent low bank wr", 12'h000, {11'h0, pwr});
    endtask : periph_test
    // Pointer write then read on consecutive edges, then the same byte seen through bank 16
    task automatic window_b2b_test;
        @(negedge clk);
        ptr_addr = 16'h2500;
        wdata = 8'hC3;
        ptr_wr = 1'h1;
        @(negedge clk);
        ptr_wr = 1'h0;
        ptr_rd = 1'h1;
        @(negedge clk);
        rd_seen = rdata;
        ptr_rd = 1'h0;
        chk("window back to back", 12'h0C3, {4'h0, rd_seen});
        set_bank(5'h10);
        acc(1'h0, 1'h0, 16'h0020, 8'h00);
        chk("window to bank", 12'h0C3, {4'h0, rd_seen});
    endtask : window_b2b_test
    // Reset in mid-run must bring the bank back to zero and clear read data
    task automatic reset_test;
        set_bank(5'h05);
        @(negedge clk);
        rst = 1'h1;
        repeat (2) @(negedge clk);
        rst = 1'h0;
        chk("bank after reset", 12'h000, {7'h00, bank});
        chk("rdata after reset", 12'h000, {4'h0, rdata});
        acc(1'h0, 1'h0, 16'h0008, 8'h00);
        chk("bank read after reset", 12'h000, {4'h0, rd_seen});
    endtask : reset_test
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'h0;
        bank_test();
        common_test();
        genram_test();
        window_b2b_test();
        periph_test();
        reset_test();
        complete_run();
    end
    initial begin
        #20000;
        mismatches++;
        complete_run();
    end
endmodule : tb
